// ---- hw/ras_pkg.sv ----
// Purpose: shared constants and types for the return address stack block
// Assumes: one clock, core sequencer and sfr port on the same clock
package ras_pkg;
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam int DEPTH = 31;
  localparam int INSTR_W = 16;
  localparam logic [PC_W-1:0] RESET_VEC = 21'h000000;
  localparam logic [PC_W-1:0] HIGH_VEC = 21'h000008;
  localparam logic [PC_W-1:0] LOW_VEC = 21'h000018;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] MEM_LIMIT_LARGE = 21'h008000; // 32 kbytes
  localparam logic [PC_W-1:0] MEM_LIMIT_SMALL = 21'h004000; // 16 kbytes
  localparam logic [SP_W-1:0] SP_EMPTY = 5'h00;
  localparam logic [SP_W-1:0] SP_TOP = 5'h1f;
  localparam logic [SP_W-1:0] SP_ONE = 5'h01;
  localparam logic [INSTR_W-1:0] INSTR_NOP = 16'h0000;
  // stack pointer byte layout
  localparam int FULL_BIT = 7;
  localparam int UNF_BIT = 6;
  localparam int UPPER_W = PC_W - 16;

  typedef enum logic [2:0] {
    RAS_SEL_TOS_UPPER,
    RAS_SEL_TOS_HIGH,
    RAS_SEL_TOS_LOW,
    RAS_SEL_SPTR,
    RAS_SEL_LATCH_UPPER,
    RAS_SEL_LATCH_HIGH
  } ras_sfr_sel_t;

  // software write strobe with its data
  typedef struct packed {
    logic en;
    ras_sfr_sel_t sel;
    logic [7:0] data;
  } ras_sfr_wr_t;

  // one-cycle commands from the instruction sequencer
  typedef struct packed {
    logic push;
    logic pop;
    logic irq_ack;
    logic irq_high;
    logic jump;
    logic advance;
    logic [PC_W-1:0] jump_addr;
  } ras_core_op_t;
endpackage : ras_pkg

// ---- hw/ras_fetch_gate.sv ----
// Purpose: zero fill for fetches beyond the implemented program memory
// Assumes: program memory data arrives combinationally for the given address
// Notes: output is registered, one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module ras_fetch_gate
  import ras_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic large_variant,
  input wire logic [PC_W-1:0] fetch_addr,
  input wire logic [INSTR_W-1:0] mem_data,
  output logic [INSTR_W-1:0] instr_out
);
  logic [INSTR_W-1:0] instr_reg;
  logic [INSTR_W-1:0] instr_next;
  logic [PC_W-1:0] limit;

  // unimplemented space reads as a no-op so a runaway pc just slides along
  always_comb begin
    limit = large_variant ? MEM_LIMIT_LARGE : MEM_LIMIT_SMALL;
    instr_next = (fetch_addr >= limit) ? INSTR_NOP : mem_data;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_reg <= INSTR_NOP;
    end else begin
      instr_reg <= instr_next;
    end
  end

  assign instr_out = instr_reg;

  a_fetch_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fetch_addr >= (large_variant ? MEM_LIMIT_LARGE : MEM_LIMIT_SMALL)
    |=> instr_out == INSTR_NOP)
    else $error("fetch beyond memory did not read zero");
endmodule : ras_fetch_gate
`default_nettype wire

// ---- hw/ras_top.sv ----
// Purpose: return address stack, program counter and vectoring of the core
// Assumes: sequencer commands and sfr writes are single-cycle, same clock
// Notes: rst_n is power-on reset; soft_reset covers every other reset
`timescale 1ns/1ps
`default_nettype none
module ras_top
  import ras_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire ras_core_op_t core_op,
  input wire logic irq_wake,
  input wire logic global_high_irq_enable,
  input wire logic global_low_irq_enable,
  input wire logic stack_overflow_reset_option,
  input wire logic large_variant,
  input wire ras_sfr_wr_t sfr_wr,
  input wire logic [INSTR_W-1:0] mem_data,
  output logic [PC_W-1:0] pc_out,
  output logic [INSTR_W-1:0] instr_out,
  output logic [7:0] stack_top_upper_byte,
  output logic [7:0] stack_top_high_byte,
  output logic [7:0] stack_top_low_byte,
  output logic [7:0] return_stack_pointer,
  output logic [7:0] pc_upper_latch,
  output logic [7:0] pc_high_latch,
  output logic stack_reset_req
);
  // stack words live here, never in program or data space
  logic [PC_W-1:0] stack_mem [1:DEPTH];

  logic [SP_W-1:0] sp_reg, sp_next;
  logic full_reg, full_next;
  logic unf_reg, unf_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic [7:0] lat_u_reg, lat_u_next;
  logic [7:0] lat_h_reg, lat_h_next;
  logic rst_req_reg, rst_req_next;
  logic [7:0] rd_u_reg, rd_h_reg, rd_l_reg, rd_sp_reg;
  logic [7:0] rd_u_next, rd_h_next, rd_l_next, rd_sp_next;
  logic [PC_W-1:0] top_word;
  logic do_irq, do_push, do_pop, any_push;
  logic mem_we;
  logic [SP_W-1:0] mem_idx;
  logic [PC_W-1:0] mem_wdata;
  logic [SP_W-1:0] push_sp;
  logic ovf_reset;
  logic unf_reset;
  logic sp_written;

  // word under the pointer; pointer zero has nothing behind it
  always_comb begin
    top_word = (sp_reg == SP_EMPTY) ? '0 : stack_mem[sp_reg];
  end

  // irq wake or acknowledge outranks a return, which outranks a push
  always_comb begin
    do_irq = core_op.irq_ack
      | (irq_wake & (global_high_irq_enable | global_low_irq_enable));
    do_pop = !do_irq & core_op.pop;
    do_push = !do_irq & !do_pop & core_op.push;
    any_push = do_irq | do_push;
    sp_written = sfr_wr.en & (sfr_wr.sel == RAS_SEL_SPTR);
  end

  // pointer for the push: increment first, saturate at the top level
  always_comb begin
    push_sp = (sp_reg == SP_TOP) ? SP_TOP : sp_reg + SP_ONE;
    ovf_reset = any_push & stack_overflow_reset_option & (push_sp == SP_TOP);
    unf_reset = do_pop & stack_overflow_reset_option & (sp_reg == SP_EMPTY);
  end

  // stack word write port; a push beats a software byte write
  always_comb begin
    mem_we = 1'b0;
    mem_idx = push_sp;
    mem_wdata = pc_reg;
    if (soft_reset) begin
      mem_we = 1'b0;
    end else if (any_push) begin
      mem_we = 1'b1;
    end else if (sfr_wr.en && sp_reg != SP_EMPTY) begin
      mem_idx = sp_reg;
      mem_wdata = top_word;
      unique case (sfr_wr.sel)
        RAS_SEL_TOS_UPPER: begin
          mem_we = 1'b1;
          mem_wdata[PC_W-1:16] = sfr_wr.data[UPPER_W-1:0];
        end
        RAS_SEL_TOS_HIGH: begin
          mem_we = 1'b1;
          mem_wdata[15:8] = sfr_wr.data;
        end
        RAS_SEL_TOS_LOW: begin
          mem_we = 1'b1;
          mem_wdata[7:0] = sfr_wr.data;
        end
        RAS_SEL_SPTR, RAS_SEL_LATCH_UPPER, RAS_SEL_LATCH_HIGH: begin
          mem_we = 1'b0;
        end
      endcase
    end
  end

  // storage has no reset; the empty pointer hides stale words
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      stack_mem[mem_idx] <= mem_wdata;
    end
  end

  // pointer, flags and program counter
  always_comb begin
    sp_next = sp_reg;
    full_next = full_reg;
    unf_next = unf_reg;
    pc_next = pc_reg;
    rst_req_next = 1'b0;
    // software clears flags by writing zero; a hardware set below wins
    if (sp_written) begin
      sp_next = sfr_wr.data[SP_W-1:0];
      full_next = full_reg & sfr_wr.data[FULL_BIT];
      unf_next = unf_reg & sfr_wr.data[UNF_BIT];
    end
    if (core_op.jump) begin
      pc_next = core_op.jump_addr;
    end else if (core_op.advance) begin
      pc_next = pc_reg + PC_STEP;
    end
    if (soft_reset) begin
      sp_next = SP_EMPTY;
      pc_next = RESET_VEC;
    end else if (any_push) begin
      sp_next = push_sp;
      if (push_sp == SP_TOP) begin
        full_next = 1'b1;
      end
      if (do_irq) begin
        pc_next = core_op.irq_high ? HIGH_VEC : LOW_VEC;
      end
      if (ovf_reset) begin
        sp_next = SP_EMPTY;
        pc_next = RESET_VEC;
        rst_req_next = 1'b1;
      end
    end else if (do_pop) begin
      pc_next = top_word;
      if (sp_reg == SP_EMPTY) begin
        unf_next = 1'b1;
        if (unf_reset) begin
          rst_req_next = 1'b1;
        end
      end else begin
        sp_next = sp_reg - SP_ONE;
      end
    end
  end

  // latch bytes change only by software; returns leave them alone
  always_comb begin
    lat_u_next = lat_u_reg;
    lat_h_next = lat_h_reg;
    if (sfr_wr.en && sfr_wr.sel == RAS_SEL_LATCH_UPPER) begin
      lat_u_next = sfr_wr.data;
    end
    if (sfr_wr.en && sfr_wr.sel == RAS_SEL_LATCH_HIGH) begin
      lat_h_next = sfr_wr.data;
    end
  end

  // read copies lag the state by one cycle so outputs come from flops
  always_comb begin
    rd_u_next = 8'h00;
    rd_u_next[UPPER_W-1:0] = top_word[PC_W-1:16];
    rd_h_next = top_word[15:8];
    rd_l_next = top_word[7:0];
    rd_sp_next = 8'h00;
    rd_sp_next[FULL_BIT] = full_reg;
    rd_sp_next[UNF_BIT] = unf_reg;
    rd_sp_next[SP_W-1:0] = sp_reg;
  end

  // flags survive every reset except power-on
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_reg <= SP_EMPTY;
      full_reg <= 1'b0;
      unf_reg <= 1'b0;
      pc_reg <= RESET_VEC;
      lat_u_reg <= 8'h00;
      lat_h_reg <= 8'h00;
      rst_req_reg <= 1'b0;
      rd_u_reg <= 8'h00;
      rd_h_reg <= 8'h00;
      rd_l_reg <= 8'h00;
      rd_sp_reg <= 8'h00;
    end else begin
      sp_reg <= sp_next;
      full_reg <= full_next;
      unf_reg <= unf_next;
      pc_reg <= pc_next;
      lat_u_reg <= lat_u_next;
      lat_h_reg <= lat_h_next;
      rst_req_reg <= rst_req_next;
      rd_u_reg <= rd_u_next;
      rd_h_reg <= rd_h_next;
      rd_l_reg <= rd_l_next;
      rd_sp_reg <= rd_sp_next;
    end
  end

  // fetch path with zero fill above implemented memory
  ras_fetch_gate u_fetch (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .large_variant(large_variant),
    .fetch_addr(pc_reg),
    .mem_data(mem_data),
    .instr_out(instr_out)
  );

  // outputs straight from flops
  assign pc_out = pc_reg;
  assign stack_top_upper_byte = rd_u_reg;
  assign stack_top_high_byte = rd_h_reg;
  assign stack_top_low_byte = rd_l_reg;
  assign return_stack_pointer = rd_sp_reg;
  assign pc_upper_latch = lat_u_reg;
  assign pc_high_latch = lat_h_reg;
  assign stack_reset_req = rst_req_reg;

  // every check runs on the core clock and rests during power-on reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // push below the top lands the old pc one level up
  a_push_order: assert property (
    any_push && !soft_reset && sp_reg < SP_TOP - SP_ONE
    |=> sp_reg == $past(sp_reg) + SP_ONE && stack_mem[sp_reg] == $past(pc_reg))
    else $error("push did not increment then store");
  a_pop_order: assert property (
    do_pop && !soft_reset && sp_reg != SP_EMPTY
    |=> pc_reg == $past(top_word) && sp_reg == $past(sp_reg) - SP_ONE)
    else $error("pop did not load then decrement");
  a_underflow_zero: assert property (
    do_pop && !soft_reset && sp_reg == SP_EMPTY
    |=> pc_reg == RESET_VEC && unf_reg && sp_reg == SP_EMPTY)
    else $error("underflow pop wrong");
  a_full_saturate: assert property (
    any_push && !soft_reset && !stack_overflow_reset_option && sp_reg >= SP_TOP - SP_ONE
    |=> sp_reg == SP_TOP && full_reg)
    else $error("full push did not saturate at top");
  a_ovf_reset: assert property (
    ovf_reset && !soft_reset
    |=> sp_reg == SP_EMPTY && full_reg && stack_reset_req ##1 !stack_reset_req)
    else $error("overflow reset sequence wrong");
  a_irq_vector: assert property (
    do_irq && !soft_reset && !ovf_reset
    |=> pc_reg == ($past(core_op.irq_high) ? HIGH_VEC : LOW_VEC))
    else $error("irq did not vector");
  a_soft_keep_flags: assert property (
    soft_reset && !sp_written
    |=> sp_reg == SP_EMPTY && pc_reg == RESET_VEC
    && full_reg == $past(full_reg) && unf_reg == $past(unf_reg))
    else $error("soft reset mishandled pointer or flags");
  a_return_latch: assert property (
    do_pop && !sfr_wr.en |=> $stable(pc_upper_latch) && $stable(pc_high_latch))
    else $error("return disturbed pc latches");
  a_read_mirror: assert property (
    sp_written && !soft_reset && !any_push && !do_pop
    |=> ##1 return_stack_pointer[SP_W-1:0] == $past(sfr_wr.data[SP_W-1:0], 2))
    else $error("pointer write not visible");

  // stepping, byte writes, sticky flags and masked wake-ups
  a_advance_step: assert property (
    core_op.advance && !core_op.jump && !any_push && !do_pop && !soft_reset
    |=> pc_reg == $past(pc_reg) + PC_STEP)
    else $error("advance did not step pc by one word");
  a_tos_low_write: assert property (
    sfr_wr.en && sfr_wr.sel == RAS_SEL_TOS_LOW && sp_reg != SP_EMPTY
    && !any_push && !do_pop && !soft_reset
    |=> top_word[7:0] == $past(sfr_wr.data))
    else $error("top byte write did not land");
  a_full_flag: assert property (
    any_push && !soft_reset && push_sp == SP_TOP |=> full_reg)
    else $error("full flag not set on last level");
  a_flags_sticky: assert property (
    !sp_written
    |=> (full_reg || !$past(full_reg)) && (unf_reg || !$past(unf_reg)))
    else $error("stack flag cleared without a pointer write");
  a_underflow_req: assert property (
    do_pop && !soft_reset && sp_reg == SP_EMPTY && stack_overflow_reset_option
    |=> stack_reset_req)
    else $error("underflow did not request reset");
  a_wake_gated: assert property (
    irq_wake && !global_high_irq_enable && !global_low_irq_enable && !core_op.irq_ack
    && !core_op.push && !core_op.pop && !core_op.jump && !core_op.advance
    && !sfr_wr.en && !soft_reset
    |=> $stable(pc_reg) && $stable(sp_reg))
    else $error("masked wake-up moved pc or pointer");
  a_latch_write: assert property (
    sfr_wr.en && sfr_wr.sel == RAS_SEL_LATCH_HIGH
    |=> pc_high_latch == $past(sfr_wr.data))
    else $error("latch byte write lost");

  // main scenarios the bench should reach
  c_irq_high: cover property (do_irq && core_op.irq_high);
  c_overflow: cover property (ovf_reset);
  c_underflow: cover property (do_pop && sp_reg == SP_EMPTY);
  c_underflow_reset: cover property (unf_reset);
  c_tos_rewrite: cover property (sfr_wr.en && sfr_wr.sel == RAS_SEL_TOS_LOW ##1 do_pop);
endmodule : ras_top
`default_nettype wire

// ---- sim/ras_seq_model.sv ----
// Purpose: sequencer and program memory model at the far side of the stack
// Assumes: strobes are raised and dropped at falling edges of sys_clk
// Notes: memory image is never zero, so a zero fetch shows the gate at work
`timescale 1ns/1ps
`default_nettype none
module ras_seq_model
  import ras_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [PC_W-1:0] pc_out,
  output var ras_core_op_t core_op,
  output var logic irq_wake,
  output logic [INSTR_W-1:0] mem_data
);
  // combinational memory word, odd pattern so it can not read as a no-op
  assign mem_data = ~pc_out[INSTR_W-1:0];

  initial begin
    core_op = '0;
    irq_wake = 1'b0;
  end

  // one-cycle command; a gap cycle keeps two strobes out of one time step
  task automatic issue(input ras_core_op_t op, input logic wake);
    @(negedge sys_clk);
    core_op = op;
    irq_wake = wake;
    @(negedge sys_clk);
    core_op = '0;
    irq_wake = 1'b0;
  endtask : issue
endmodule : ras_seq_model
`default_nettype wire

// ---- sim/test_return_address_stack.sv ----
// Purpose: self-checking bench for the return address stack
// Assumes: inputs change at falling edges, outputs checked there too
// Notes: pointer byte lags pc by one cycle, so sp() waits an extra edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("MISMATCH at %0t: %s", $time, msg); \
  end \
end
module test_return_address_stack;
  import ras_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic soft_reset = 1'b0;
  // enables stay low while the stack top is edited
  logic global_high_irq_enable = 1'b0;
  logic global_low_irq_enable = 1'b0;
  logic stack_overflow_reset_option = 1'b0;
  logic large_variant = 1'b1;
  ras_sfr_wr_t sfr_wr = '0;
  ras_core_op_t core_op;
  logic irq_wake;
  logic [INSTR_W-1:0] mem_data;
  logic [PC_W-1:0] pc_out;
  logic [INSTR_W-1:0] instr_out;
  logic [7:0] tos_u, tos_h, tos_l, rsp, lat_u, lat_h;
  logic stack_reset_req;
  int checks = 0;
  int miscompares = 0;
  int cycles = 0;

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  ras_seq_model i_ras_seq_model (.sys_clk(sys_clk), .pc_out(pc_out), .core_op(core_op),
    .irq_wake(irq_wake), .mem_data(mem_data));

  ras_top i_ras_top (.sys_clk(sys_clk), .rst_n(rst_n), .soft_reset(soft_reset),
    .core_op(core_op), .irq_wake(irq_wake), .global_high_irq_enable(global_high_irq_enable),
    .global_low_irq_enable(global_low_irq_enable),
    .stack_overflow_reset_option(stack_overflow_reset_option),
    .large_variant(large_variant), .sfr_wr(sfr_wr), .mem_data(mem_data), .pc_out(pc_out),
    .instr_out(instr_out), .stack_top_upper_byte(tos_u), .stack_top_high_byte(tos_h),
    .stack_top_low_byte(tos_l), .return_stack_pointer(rsp), .pc_upper_latch(lat_u),
    .pc_high_latch(lat_h), .stack_reset_req(stack_reset_req));

  // kind: 0 push, 1 pop, 2 irq ack, 3 jump, 4 wake-up, 5 advance
  task automatic op(input int k, input logic [PC_W-1:0] a, input logic hi);
    ras_core_op_t o;
    o = '0;
    o.push = (k == 0);
    o.pop = (k == 1);
    o.irq_ack = (k == 2);
    o.jump = (k == 3);
    o.advance = (k == 5);
    o.irq_high = hi;
    o.jump_addr = a;
    i_ras_seq_model.issue(o, k == 4);
  endtask : op

  task automatic wr(input ras_sfr_sel_t s, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_wr = '{en: 1'b1, sel: s, data: d};
    @(negedge sys_clk);
    sfr_wr = '0;
  endtask : wr

  task automatic sp(input logic [7:0] e);
    @(negedge sys_clk);
    `CHK(rsp, e, "stack pointer byte")
  endtask : sp

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // hang guard, run needs under a hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    `CHK(pc_out, RESET_VEC, "reset pc")
    `CHK(rsp, 8'h00, "reset pointer")
    wr(RAS_SEL_LATCH_HIGH, 8'h5a);
    wr(RAS_SEL_LATCH_UPPER, 8'h03);
    op(3, 21'h012344, 1'b0);
    `CHK(pc_out, 21'h012344, "wide pc")
    op(0, '0, 1'b0);
    sp(8'h01);
    `CHK({tos_u, tos_h, tos_l}, 24'h012344, "top bytes")
    op(3, 21'h000100, 1'b0);
    op(0, '0, 1'b0);
    sp(8'h02);
    op(1, '0, 1'b0);
    `CHK(pc_out, 21'h000100, "pop value")
    sp(8'h01);
    `CHK({lat_u, lat_h}, 16'h035a, "latches kept")
    wr(RAS_SEL_TOS_LOW, 8'h50);
    wr(RAS_SEL_TOS_HIGH, 8'h06);
    wr(RAS_SEL_TOS_UPPER, 8'h00);
    op(1, '0, 1'b0);
    `CHK(pc_out, 21'h000650, "rewritten return")
    sp(8'h00);
    `CHK(tos_l, 8'h00, "no word at zero")
    op(1, '0, 1'b0);
    `CHK({pc_out, stack_reset_req}, 22'h0, "underflow pop")
    sp(8'h40);
    soft_reset = 1'b1;
    @(negedge sys_clk);
    soft_reset = 1'b0;
    sp(8'h40);
    wr(RAS_SEL_SPTR, 8'h00);
    sp(8'h00);
    op(3, 21'h000200, 1'b0);
    op(2, '0, 1'b1);
    `CHK(pc_out, HIGH_VEC, "high vector")
    sp(8'h01);
    `CHK({tos_h, tos_l}, 16'h0200, "irq saved pc")
    op(4, '0, 1'b0);
    `CHK(pc_out, HIGH_VEC, "wake with enables off")
    global_low_irq_enable = 1'b1;
    op(4, '0, 1'b0);
    `CHK(pc_out, LOW_VEC, "low vector on wake")
    sp(8'h02);
    `CHK(tos_l, 8'h08, "wake saved pc")
    global_low_irq_enable = 1'b0;
    wr(RAS_SEL_SPTR, 8'h1d);
    sp(8'h1d);
    op(0, '0, 1'b0);
    sp(8'h1e);
    op(3, 21'h000400, 1'b0);
    op(0, '0, 1'b0);
    sp(8'h9f);
    op(3, 21'h000600, 1'b0);
    op(0, '0, 1'b0);
    sp(8'h9f);
    `CHK(tos_h, 8'h06, "level 31 overwritten")
    stack_overflow_reset_option = 1'b1;
    wr(RAS_SEL_SPTR, 8'h1e);
    sp(8'h1e);
    op(0, '0, 1'b0);
    `CHK({pc_out, stack_reset_req}, 22'h1, "overflow reset")
    sp(8'h80);
    `CHK(stack_reset_req, 1'b0, "reset request one cycle")
    op(1, '0, 1'b0);
    `CHK({pc_out, stack_reset_req}, 22'h1, "underflow reset request")
    sp(8'hc0);
    stack_overflow_reset_option = 1'b0;
    op(3, MEM_LIMIT_LARGE, 1'b0);
    @(negedge sys_clk);
    `CHK(instr_out, INSTR_NOP, "beyond 32k")
    op(3, 21'h007ffe, 1'b0);
    @(negedge sys_clk);
    `CHK(instr_out, 16'h8001, "inside 32k")
    large_variant = 1'b0;
    op(3, MEM_LIMIT_SMALL, 1'b0);
    @(negedge sys_clk);
    `CHK(instr_out, INSTR_NOP, "beyond 16k")
    op(3, 21'h003ffe, 1'b0);
    @(negedge sys_clk);
    `CHK(instr_out, 16'hc001, "inside 16k")
    op(5, '0, 1'b0);
    `CHK(pc_out, MEM_LIMIT_SMALL, "advance by one word")
    @(negedge sys_clk);
    `CHK(instr_out, INSTR_NOP, "advanced past 16k")
    // power-on reset in mid-run with both flags set
    rst_n = 1'b0;
    @(negedge sys_clk);
    rst_n = 1'b1;
    `CHK(pc_out, RESET_VEC, "pc after power-on")
    sp(8'h00);
    wrap_up();
  end
endmodule : test_return_address_stack
`default_nettype wire
